/* inc/nic_glue_pkg.sv */
// constants, states and signal bundles for the network controller bus glue
// Operation
// R1: controller picks its bus style by strap; this glue drives the strap high
// R2: address buffers drive only while controller owns bus, strobe and ALE up
// R3: register address follows the bus while processor master holds ALE high
// R4: slave read data reaches the bus only after processor permits data drive
// R5: master write data reaches the bus only after the master ALE drops
// R6: bus-to-controller buffer opens on slave writes and memory-driven reads
// R7: processor ALE falling edge captures decoder hit and register address
// R8: decode hit drives chip select and slave strobe on the next clock
// R9: processor acknowledge or read-valid follows controller done by two clocks
// R10: processor acknowledge or read-valid stands exactly one clock
// R11: dropping the acknowledge also drops chip select and slave strobe
// R12: controller bus request is passed on to the processor request
// R13: processor grant is handed to the controller without sequencing
// R14: controller confirms the grant, starts transfers and drops its request
// R15: processor request is controller request ORed with grant confirm
// R16: controller finishes each word transfer in three cycles given fast memory
// R17: master ALE rises in the second access cycle and falls within it; here ALE stays high for one full clock
// R18: master read data-drive permit is a delayed copy of the master ALE
// R19: controller address strobe turns its read/write line into rd or wr strobe
// R20: system rd or wr strobe drops on the last cycle of the master access
// R21: controller answers as a 64-word register space, about seven cycles
// R22: reset returns all machines to idle with every enable and strobe off
package nic_glue_pkg;

  localparam int          REG_ADDR_W          = 6;
  localparam int          CLK_PERIOD_NS       = 10;
  localparam int          ACK_DELAY_CLOCKS    = 2;
  localparam int          ACK_PIPE_DEPTH      = ACK_DELAY_CLOCKS - 1;
  localparam int          PERMIT_DELAY_CLOCKS = 1;
  localparam logic        BUS_STYLE_STRAP_VAL = 1'b1;
  localparam logic [REG_ADDR_W-1:0] REG_ADDR_RESET = 6'h00;

  typedef enum logic [1:0] {
    SL_IDLE   = 2'b00,
    SL_SELECT = 2'b01,
    SL_DELAY  = 2'b10,
    SL_ACK    = 2'b11
  } slave_state_t;

  typedef enum logic [1:0] {
    MS_IDLE = 2'b00,
    MS_ADDR = 2'b01,
    MS_ALE  = 2'b10,
    MS_DATA = 2'b11
  } master_state_t;

  // processor side inputs
  typedef struct packed {
    logic                  ale;
    logic                  decodeHit;
    logic                  readNotWrite;
    logic                  dataDrivePermitN;
    logic                  busGrantN;
    logic [REG_ADDR_W-1:0] regAddrLines;
  } cpu_in_t;

  // controller side inputs
  typedef struct packed {
    logic slaveDoneFromNicN;
    logic nicBusRequestN;
    logic grantConfirmN;
    logic masterAddressStrobeN;
    logic memReadWrite;
    logic widthHandshakeN;
  } nic_in_t;

  // processor and system bus outputs
  typedef struct packed {
    logic ackN;
    logic readDataValidN;
    logic cpuBusRequestN;
    logic sysAle;
    logic dataDrivePermitN;
    logic sysRdN;
    logic sysWrN;
  } cpu_out_t;

  // controller side outputs
  typedef struct packed {
    logic                  chipSelectN;
    logic                  slaveAddrStrobeN;
    logic                  nicBusGrantN;
    logic                  busStyleStrap;
    logic [REG_ADDR_W-1:0] regAddr;
  } nic_out_t;

  // buffer enables, active low
  typedef struct packed {
    logic addrBufOeN;
    logic nicToBusOeN;
    logic busToNicOeN;
  } buf_out_t;

  localparam cpu_out_t CPU_OUT_RESET = '{ackN: 1'b1, readDataValidN: 1'b1,
    cpuBusRequestN: 1'b1, sysAle: 1'b0, dataDrivePermitN: 1'b1,
    sysRdN: 1'b1, sysWrN: 1'b1};
  localparam nic_out_t NIC_OUT_RESET = '{chipSelectN: 1'b1,
    slaveAddrStrobeN: 1'b1, nicBusGrantN: 1'b1,
    busStyleStrap: BUS_STYLE_STRAP_VAL, regAddr: REG_ADDR_RESET};
  localparam buf_out_t BUF_OUT_RESET = '{addrBufOeN: 1'b1,
    nicToBusOeN: 1'b1, busToNicOeN: 1'b1};

endpackage : nic_glue_pkg

/* rtl/delay_pipe.sv */
// fixed-length pulse delay line
`timescale 1ns/1ps
`default_nettype none
module delay_pipe #(
  parameter int DEPTH = 1
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic din,
  output var  logic dout
);

  typedef struct packed {
    logic [DEPTH-1:0] taps;
  } pipe_state_t;

  pipe_state_t stateQ;
  pipe_state_t stateD;

  // each tap takes the one before it
  always_comb begin
    stateD = stateQ;
    for (int i = DEPTH - 1; i > 0; i--) begin
      stateD.taps[i] = stateQ.taps[i-1];
    end
    stateD.taps[0] = din;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stateQ <= '0;
    end else begin
      stateQ <= stateD;
    end
  end

  assign dout = stateQ.taps[DEPTH-1];

endmodule : delay_pipe
`default_nettype wire

/* rtl/nic_cpu_bus_glue.sv */
// glue between a multiplexed processor bus and a demultiplexed nic
`timescale 1ns/1ps
`default_nettype none
module nic_cpu_bus_glue (
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire nic_glue_pkg::cpu_in_t cpuIn,
  input  wire nic_glue_pkg::nic_in_t nicIn,
  output var  nic_glue_pkg::cpu_out_t cpuOut,
  output var  nic_glue_pkg::nic_out_t nicOut,
  output var  nic_glue_pkg::buf_out_t bufOut
);

  // whole module state in one record
  typedef struct packed {
    nic_glue_pkg::slave_state_t  slaveState;
    nic_glue_pkg::master_state_t masterState;
    logic                        aleSeen;
    logic                        strobeSeen;
    logic                        selectDecodeHit;
    logic                        slaveRead;
    logic                        masterRead;
    nic_glue_pkg::cpu_out_t      cpuOut;
    nic_glue_pkg::nic_out_t      nicOut;
    nic_glue_pkg::buf_out_t      bufOut;
  } glue_state_t;

  glue_state_t stateQ;
  glue_state_t stateD;

  logic ackPipeIn;
  logic ackPipeOut;
  logic permitPipeOut;

  // controller owns the bus while it confirms the grant
  logic nicOwnsBus;
  logic cpuOwnsBus;
  logic cpuAleFall;
  logic strobeFall;

  assign nicOwnsBus = ~nicIn.grantConfirmN;
  assign cpuOwnsBus = nicIn.grantConfirmN;
  assign cpuAleFall = stateQ.aleSeen & ~cpuIn.ale;
  assign strobeFall = stateQ.strobeSeen & nicIn.masterAddressStrobeN;

  // done pulse starts here; one pipe stage plus the ack flop gives two clocks
  assign ackPipeIn = (stateQ.slaveState == nic_glue_pkg::SL_SELECT) &
                     ~nicIn.slaveDoneFromNicN;

  delay_pipe #(
    .DEPTH (nic_glue_pkg::ACK_PIPE_DEPTH)
  ) ackDelay (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     (ackPipeIn),
    .dout    (ackPipeOut)
  );

  // permit is the master ALE delayed, so buffers turn off before memory drives
  delay_pipe #(
    .DEPTH (nic_glue_pkg::PERMIT_DELAY_CLOCKS)
  ) permitDelay (
    .clk     (clk),
    .sys_rst (sys_rst),
    .din     (stateQ.cpuOut.sysAle),
    .dout    (permitPipeOut)
  );

  // next state for all machines and outputs
  always_comb begin
    stateD = stateQ;

    // edge detectors on processor ALE and controller address strobe
    stateD.aleSeen    = cpuIn.ale;
    stateD.strobeSeen = ~nicIn.masterAddressStrobeN;

    // the strap never changes; it is held in a flop only to keep outputs clean
    stateD.nicOut.busStyleStrap = nic_glue_pkg::BUS_STYLE_STRAP_VAL; // R1

    // ---------------- register address latch and decode capture
    // address follows the bus while ALE is high, freezes as ALE drops
    if (cpuOwnsBus && cpuIn.ale) begin
      stateD.nicOut.regAddr = cpuIn.regAddrLines; // R3
    end
    // decode result is only taken at the ALE fall, when the address is stable
    if (cpuOwnsBus && cpuAleFall &&
        stateQ.slaveState == nic_glue_pkg::SL_IDLE) begin
      stateD.nicOut.regAddr  = cpuIn.regAddrLines; // R7
      stateD.selectDecodeHit = cpuIn.decodeHit; // R7
      stateD.slaveRead       = cpuIn.readNotWrite;
    end

    // ---------------- slave sequencing
    unique case (stateQ.slaveState)
      nic_glue_pkg::SL_IDLE: begin
        if (stateQ.selectDecodeHit) begin
          stateD.nicOut.chipSelectN      = 1'b0; // R8
          stateD.nicOut.slaveAddrStrobeN = 1'b0; // R8
          stateD.slaveState              = nic_glue_pkg::SL_SELECT;
        end
      end
      nic_glue_pkg::SL_SELECT: begin
        if (ackPipeIn) begin
          stateD.slaveState = nic_glue_pkg::SL_DELAY;
        end
      end
      nic_glue_pkg::SL_DELAY: begin
        if (ackPipeOut) begin
          stateD.cpuOut.ackN           = stateQ.slaveRead; // R9
          stateD.cpuOut.readDataValidN = ~stateQ.slaveRead; // R9
          stateD.slaveState            = nic_glue_pkg::SL_ACK;
        end
      end
      nic_glue_pkg::SL_ACK: begin
        // one clock of acknowledge, then release the controller too
        stateD.cpuOut.ackN             = 1'b1; // R10
        stateD.cpuOut.readDataValidN   = 1'b1; // R10
        stateD.nicOut.chipSelectN      = 1'b1; // R11
        stateD.nicOut.slaveAddrStrobeN = 1'b1; // R11
        stateD.selectDecodeHit         = 1'b0;
        stateD.slaveState              = nic_glue_pkg::SL_IDLE;
      end
    endcase

    // ---------------- bus request relay
    // OR of request and confirm keeps the grant for the whole tenure
    stateD.cpuOut.cpuBusRequestN = nicIn.nicBusRequestN &
                                   nicIn.grantConfirmN; // R12 R15
    // grant copied as is; the flop adds one clock but no handshake
    stateD.nicOut.nicBusGrantN = cpuIn.busGrantN; // R13

    // ---------------- master sequencing
    unique case (stateQ.masterState)
      nic_glue_pkg::MS_IDLE: begin
        if (nicOwnsBus && ~nicIn.masterAddressStrobeN) begin
          stateD.masterRead  = nicIn.memReadWrite;
          stateD.masterState = nic_glue_pkg::MS_ADDR;
        end
      end
      nic_glue_pkg::MS_ADDR: begin
        // second access cycle: ALE up and address buffers on
        stateD.cpuOut.sysAle    = 1'b1; // R17
        stateD.bufOut.addrBufOeN = ~(nicOwnsBus &
                                    ~nicIn.masterAddressStrobeN); // R2
        stateD.masterState      = nic_glue_pkg::MS_ALE;
      end
      nic_glue_pkg::MS_ALE: begin
        // a full clock of ALE is the shortest this single-edge design can do
        stateD.cpuOut.sysAle     = 1'b0; // R17
        stateD.bufOut.addrBufOeN = 1'b1; // R2
        stateD.masterState       = nic_glue_pkg::MS_DATA;
      end
      nic_glue_pkg::MS_DATA: begin
        if (~nicIn.widthHandshakeN || ~nicOwnsBus) begin
          stateD.masterState = nic_glue_pkg::MS_IDLE;
        end
      end
    endcase

    // read/write strobe from the controller line at its strobe edge
    if (nicOwnsBus && ~nicIn.masterAddressStrobeN && ~stateQ.strobeSeen) begin
      stateD.cpuOut.sysRdN = ~nicIn.memReadWrite; // R19
      stateD.cpuOut.sysWrN = nicIn.memReadWrite; // R19
    end

    // data-drive permit on reads, once ALE has gone low
    stateD.cpuOut.dataDrivePermitN = 1'b1;
    if (stateQ.masterState == nic_glue_pkg::MS_DATA && stateQ.masterRead &&
        (permitPipeOut || ~stateQ.cpuOut.dataDrivePermitN)) begin
      stateD.cpuOut.dataDrivePermitN = 1'b0; // R18
    end

    // ---------------- data buffers
    stateD.bufOut.nicToBusOeN = 1'b1;
    stateD.bufOut.busToNicOeN = 1'b1;
    // slave read: drive only when the processor lets go of the bus
    if (stateQ.slaveState != nic_glue_pkg::SL_IDLE && stateQ.slaveRead &&
        ~cpuIn.dataDrivePermitN) begin
      stateD.bufOut.nicToBusOeN = 1'b0; // R4
    end
    // slave write: bus carries data for the controller registers
    if (stateQ.slaveState != nic_glue_pkg::SL_IDLE && ~stateQ.slaveRead &&
        ~cpuIn.dataDrivePermitN) begin
      stateD.bufOut.busToNicOeN = 1'b0; // R6
    end
    // master write: only after ALE has dropped the address drivers
    if (stateQ.masterState == nic_glue_pkg::MS_DATA && ~stateQ.masterRead &&
        ~stateQ.cpuOut.sysAle) begin
      stateD.bufOut.nicToBusOeN = 1'b0; // R5
    end
    // master read: memory drives once the permit is out
    if (stateQ.masterState == nic_glue_pkg::MS_DATA && stateQ.masterRead &&
        ~stateD.cpuOut.dataDrivePermitN) begin
      stateD.bufOut.busToNicOeN = 1'b0; // R6
    end

    // ---------------- end of master access
    // last cycle is flagged by the memory handshake; strobes end with it
    if (stateQ.masterState == nic_glue_pkg::MS_DATA &&
        (~nicIn.widthHandshakeN || ~nicOwnsBus)) begin
      stateD.cpuOut.sysRdN           = 1'b1; // R20
      stateD.cpuOut.sysWrN           = 1'b1; // R20
      stateD.cpuOut.dataDrivePermitN = 1'b1;
      stateD.bufOut.nicToBusOeN      = 1'b1;
      stateD.bufOut.busToNicOeN      = 1'b1;
    end
    // a strobe that ends early also closes out a stuck access
    if (strobeFall && stateQ.masterState == nic_glue_pkg::MS_IDLE) begin
      stateD.cpuOut.sysRdN = 1'b1;
      stateD.cpuOut.sysWrN = 1'b1;
    end
  end

  // state register, reset to idle with everything released
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stateQ.slaveState      <= nic_glue_pkg::SL_IDLE; // R22
      stateQ.masterState     <= nic_glue_pkg::MS_IDLE; // R22
      stateQ.aleSeen         <= 1'b0;
      stateQ.strobeSeen      <= 1'b0;
      stateQ.selectDecodeHit <= 1'b0;
      stateQ.slaveRead       <= 1'b0;
      stateQ.masterRead      <= 1'b0;
      stateQ.cpuOut          <= nic_glue_pkg::CPU_OUT_RESET; // R22
      stateQ.nicOut          <= nic_glue_pkg::NIC_OUT_RESET; // R22
      stateQ.bufOut          <= nic_glue_pkg::BUF_OUT_RESET; // R22
    end else begin
      stateQ <= stateD;
    end
  end

  // outputs come straight from the state flops
  assign cpuOut = stateQ.cpuOut;
  assign nicOut = stateQ.nicOut;
  assign bufOut = stateQ.bufOut;

endmodule : nic_cpu_bus_glue
`default_nettype wire

/* verif/nic_glue_monitor.sv */
// concurrent checks on the bus glue ports
`timescale 1ns/1ps
`default_nettype none
module nic_glue_monitor (
  input wire logic                   clk,
  input wire logic                   sys_rst,
  input wire nic_glue_pkg::cpu_in_t  cpuIn,
  input wire nic_glue_pkg::nic_in_t  nicIn,
  input wire nic_glue_pkg::cpu_out_t cpuOut,
  input wire nic_glue_pkg::nic_out_t nicOut,
  input wire nic_glue_pkg::buf_out_t bufOut
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // slave side: select, two-clock acknowledge, one-cycle pulse, release
  a_select_after_ale: assert property (
    ($fell(cpuIn.ale) && cpuIn.decodeHit && nicIn.grantConfirmN
    && nicOut.chipSelectN) |-> ##[1:2] !nicOut.chipSelectN
    && !nicOut.slaveAddrStrobeN) else $error("select late");
  a_ack_two_clocks: assert property (
    ($fell(nicIn.slaveDoneFromNicN) && !nicOut.chipSelectN) |->
    ##1 (cpuOut.ackN && cpuOut.readDataValidN)
    ##1 (cpuOut.ackN != cpuOut.readDataValidN)) else $error("ack timing");
  a_ack_one_cycle: assert property (
    ($fell(cpuOut.ackN) || $fell(cpuOut.readDataValidN)) |=>
    (cpuOut.ackN && cpuOut.readDataValidN)) else $error("ack width");
  a_select_drop: assert property (
    ($rose(cpuOut.ackN) || $rose(cpuOut.readDataValidN)) |->
    ($rose(nicOut.chipSelectN) && $rose(nicOut.slaveAddrStrobeN)))
    else $error("select held");
  a_slave_data_gate: assert property (
    (nicIn.grantConfirmN && $fell(bufOut.nicToBusOeN)) |->
    !$past(cpuIn.dataDrivePermitN)) else $error("early read data");

  // request relay and grant pass-through
  a_req_or_confirm: assert property (
    !$past(sys_rst) |-> cpuOut.cpuBusRequestN ==
    $past(nicIn.nicBusRequestN && nicIn.grantConfirmN)) else $error("req");
  a_grant_through: assert property (
    !$past(sys_rst) |-> nicOut.nicBusGrantN == $past(cpuIn.busGrantN))
    else $error("grant");

  // master side: strobe, ALE pulse, permit and release
  a_strobe_then_ale: assert property (
    ($fell(nicIn.masterAddressStrobeN) && !nicIn.grantConfirmN
    && cpuOut.sysRdN && cpuOut.sysWrN) |=>
    ($past(nicIn.memReadWrite) ? !cpuOut.sysRdN : !cpuOut.sysWrN)
    ##1 cpuOut.sysAle ##1 !cpuOut.sysAle) else $error("strobe or ale");
  a_ale_gates_addr: assert property (
    !bufOut.addrBufOeN |-> (cpuOut.sysAle && !nicIn.grantConfirmN
    && !nicIn.masterAddressStrobeN)) else $error("address buffer");
  a_permit_after_ale: assert property (
    ($fell(cpuOut.sysAle) && !cpuOut.sysRdN) |=>
    (!cpuOut.dataDrivePermitN && !bufOut.busToNicOeN)) else $error("permit");
  a_strobe_release: assert property (
    (!nicIn.widthHandshakeN && !nicIn.grantConfirmN
    && (!cpuOut.sysRdN || !cpuOut.sysWrN)) |=> (cpuOut.sysRdN
    && cpuOut.sysWrN && cpuOut.dataDrivePermitN)) else $error("release");

  // main scenarios reached
  c_write_ack: cover property ($fell(cpuOut.ackN));
  c_read_valid: cover property ($fell(cpuOut.readDataValidN));
  c_master_write: cover property (cpuOut.sysAle && !cpuOut.sysWrN);
endmodule : nic_glue_monitor
`default_nettype wire

bind nic_cpu_bus_glue nic_glue_monitor mon (.clk(clk), .sys_rst(sys_rst),
  .cpuIn(cpuIn), .nicIn(nicIn), .cpuOut(cpuOut), .nicOut(nicOut),
  .bufOut(bufOut));

/* verif/nic_far_model.sv */
// controller-side model: register replies and dma tenures
`timescale 1ns/1ps
`default_nettype none
module nic_far_model (
  input  wire logic                   clk,
  input  wire logic [7:0]             smackWait,
  input  wire nic_glue_pkg::nic_out_t nicOut,
  output var  nic_glue_pkg::nic_in_t  nicIn,
  output var  logic                   stuck
);
  int cnt;

  initial begin
    nicIn = '1;
    stuck = 1'b0;
    cnt = 0;
  end

  task automatic tk;
    @(posedge clk);
    #1;
  endtask : tk

  // register reply: one-cycle done pulse a set time after select
  always @(posedge clk) begin
    #1;
    nicIn.slaveDoneFromNicN = 1'b1;
    // direction line floats when not master, so never let it sit still
    if (nicIn.grantConfirmN) nicIn.memReadWrite = ~nicIn.memReadWrite;
    if (nicOut.chipSelectN) cnt = 0;
    else begin
      if (cnt == 32'(smackWait)) nicIn.slaveDoneFromNicN = 1'b0;
      cnt++;
    end
  end

  // one tenure, one word; waits models slower memory
  task automatic dma(input logic rd, input int waits);
    int i;
    nicIn.nicBusRequestN = 1'b0;
    for (i = 0; i < 20 && nicOut.nicBusGrantN !== 1'b0; i++) tk();
    stuck = (i == 20);
    nicIn.grantConfirmN = 1'b0;
    nicIn.nicBusRequestN = 1'b1;
    nicIn.memReadWrite = rd;
    tk();
    nicIn.masterAddressStrobeN = 1'b0;
    // three transfer cycles behind the glue's own address cycle; the
    // full-clock ALE means a shorter strobe would never open the data path
    repeat (4 + waits) tk();
    nicIn.widthHandshakeN = 1'b0;
    tk();
    nicIn.widthHandshakeN = 1'b1;
    nicIn.masterAddressStrobeN = 1'b1;
    tk();
    nicIn.grantConfirmN = 1'b1;
  endtask : dma
endmodule : nic_far_model
`default_nettype wire

/* verif/nic_cpu_bus_glue_tb_top.sv */
// self-checking bench for the bus glue
`timescale 1ns/1ps
`default_nettype none
module nic_cpu_bus_glue_tb_top;
  logic                   clk;
  logic                   sys_rst;
  logic [7:0]             smackWait;
  logic                   stuck;
  nic_glue_pkg::cpu_in_t  cpuIn;
  nic_glue_pkg::nic_in_t  nicIn;
  nic_glue_pkg::cpu_out_t cpuOut;
  nic_glue_pkg::nic_out_t nicOut;
  nic_glue_pkg::buf_out_t bufOut;
  int                     n_mismatch = 0;
  int                     samples_checked = 0;

  nic_cpu_bus_glue dut (.clk(clk), .sys_rst(sys_rst), .cpuIn(cpuIn),
    .nicIn(nicIn), .cpuOut(cpuOut), .nicOut(nicOut), .bufOut(bufOut));
  nic_far_model far (.clk(clk), .smackWait(smackWait), .nicOut(nicOut),
    .nicIn(nicIn), .stuck(stuck));

  always #5 clk = ~clk;
  // processor grants whenever the request line is low
  always @(posedge clk) #1 cpuIn.busGrantN = !(cpuOut.cpuBusRequestN === 0);

  task automatic tk;
    @(posedge clk);
    #1;
  endtask : tk

  task automatic chk(input string what, input logic [15:0] exp,
      input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test

  // outputs while reset is held
  task automatic reset_values;
    chk("cpuOut", 16'(nic_glue_pkg::CPU_OUT_RESET), 16'(cpuOut));
    chk("nicOut", 16'(nic_glue_pkg::NIC_OUT_RESET), 16'(nicOut));
    chk("bufOut", 16'(nic_glue_pkg::BUF_OUT_RESET), 16'(bufOut));
    chk("strap", 16'h0001, 16'(nicOut.busStyleStrap));
  endtask : reset_values

  // register access; lines change after the ALE fall to prove the latch
  task automatic slave_access(input logic rd, input logic hit,
      input logic [5:0] addr, input logic [7:0] slow);
    int i;
    smackWait = slow;
    cpuIn.ale = 1'b1;
    cpuIn.decodeHit = hit;
    cpuIn.readNotWrite = rd;
    cpuIn.regAddrLines = addr;
    tk();
    chk("regAddrOpen", 16'(addr), 16'(nicOut.regAddr));
    cpuIn.ale = 1'b0;
    tk();
    cpuIn.regAddrLines = ~addr;
    tk();
    chk("regAddr", 16'(addr), 16'(nicOut.regAddr));
    chk("selectN", 16'(!hit), 16'(nicOut.chipSelectN));
    chk("strobeN", 16'(!hit), 16'(nicOut.slaveAddrStrobeN));
    cpuIn.dataDrivePermitN = 1'b0;
    if (hit) begin
      for (i = 0; i < 20 && cpuOut.ackN && cpuOut.readDataValidN; i++) tk();
      if (i == 20) begin
        n_mismatch++;
        end_of_test();
      end
      chk("ackDelay", 16'(slow) + 16'(nic_glue_pkg::ACK_DELAY_CLOCKS),
        16'(i));
      chk("ackN", 16'(rd), 16'(cpuOut.ackN));
      chk("rdValidN", 16'(!rd), 16'(cpuOut.readDataValidN));
      chk("toBusOeN", 16'(!rd), 16'(bufOut.nicToBusOeN));
      chk("toNicOeN", 16'(rd), 16'(bufOut.busToNicOeN));
      tk();
      chk("ackEnd", 16'd3, {14'd0, cpuOut.ackN, cpuOut.readDataValidN});
    end
    else repeat (4) tk();
    chk("selEnd", 16'd3, {14'd0, nicOut.chipSelectN,
      nicOut.slaveAddrStrobeN});
    cpuIn.dataDrivePermitN = 1'b1;
    cpuIn.decodeHit = 1'b0;
    tk();
    tk();
  endtask : slave_access

  // one dma word while watching request, strobes, ALE and buffers
  task automatic dma_access(input logic rd, input int waits);
    logic [5:0] seen;
    seen = '0;
    fork
      far.dma(rd, waits);
      repeat (18) begin
        tk();
        seen |= {!cpuOut.cpuBusRequestN, cpuOut.sysAle, !bufOut.addrBufOeN,
          rd ? !cpuOut.sysRdN : !cpuOut.sysWrN,
          rd ? !cpuOut.sysWrN : !cpuOut.sysRdN,
          rd ? !bufOut.busToNicOeN : !bufOut.nicToBusOeN};
      end
    join
    chk("dmaSeen", 16'h003D, 16'(seen));
    chk("dmaEnd", 16'h00FE, {8'd0, cpuOut.sysRdN, cpuOut.sysWrN,
      cpuOut.dataDrivePermitN, cpuOut.cpuBusRequestN, bufOut.addrBufOeN,
      bufOut.nicToBusOeN, bufOut.busToNicOeN, cpuOut.sysAle});
    chk("grantWait", 16'h0000, 16'(stuck));
    // a grant that never came leaves nothing worth running after it
    if (stuck) end_of_test();
  endtask : dma_access

  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    smackWait = 8'h00;
    cpuIn = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 6'h00};
    repeat (6) tk();
    reset_values();
    sys_rst = 1'b0;
    tk();
    slave_access(1'b0, 1'b1, 6'h2A, 8'h00);
    slave_access(1'b1, 1'b1, 6'h15, 8'h03);
    slave_access(1'b1, 1'b0, 6'h3F, 8'h00);
    dma_access(1'b1, 0);
    dma_access(1'b0, 2);
    dma_access(1'b1, 2);
    slave_access(1'b0, 1'b1, 6'h00, 8'h01);
    end_of_test();
  end
endmodule : nic_cpu_bus_glue_tb_top
`default_nettype wire
